// File: asp89_baud_timer.v
// Eight-bit auto-reload timer with a divide-by-two baud output.
// A force input reloads the count and primes the divider so the first
// baud strobe lands one overflow (half a bit) later: used by the receiver.
`default_nettype none
`include "asp89_consts.vh"

module asp89_baud_timer (
    input  wire       ref_clk_in,  // System clock
    input  wire       reset_n_in,  // Async reset, active low
    input  wire       tick_in,     // Timer clock tick
    input  wire [7:0] reload_in,   // Reload byte
    input  wire       force_in,    // Force reload, prime divider
    input  wire       load_in,     // Software load of count
    input  wire [7:0] load_val_in, // Value for software load
    output reg  [7:0] count_out,   // Current count
    output wire       baud_out     // One-cycle baud strobe
);
    reg  half_q;
    wire ovf;

    assign ovf      = tick_in && (count_out == `ASP89_TMR_TOP) && !force_in;
    assign baud_out = ovf && half_q;

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            count_out <= `ASP89_ZERO8;
            half_q    <= 1'b0;
        end else if (force_in) begin
            count_out <= reload_in;
            half_q    <= 1'b1;
        end else if (load_in) begin
            count_out <= load_val_in;
        end else if (tick_in) begin
            if (count_out == `ASP89_TMR_TOP) begin
                count_out <= reload_in;
                half_q    <= !half_q;
            end else begin
                count_out <= count_out + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: asp89_consts.vh
// Constants for the 8/9-bit asynchronous serial port: register offsets,
// control bit positions, reset values and prescaler terminal counts.
// Assumes it is included by every design file of the port.
`ifndef ASP89_CONSTS_VH
`define ASP89_CONSTS_VH

// Register offsets on the plain register port
`define ASP89_OFS_CTRL      3'h0
`define ASP89_OFS_DATA      3'h1
`define ASP89_OFS_RELOAD    3'h2
`define ASP89_OFS_TMRCFG    3'h3
`define ASP89_OFS_TMRLOW    3'h4

// Control register bit positions
`define ASP89_CTL_MODE      7
`define ASP89_CTL_UNUSED    6
`define ASP89_CTL_MCE       5
`define ASP89_CTL_REN       4
`define ASP89_CTL_TB8       3
`define ASP89_CTL_RB8       2
`define ASP89_CTL_TI        1
`define ASP89_CTL_RI        0

// Timer configuration register fields
`define ASP89_TCFG_RUN      0
`define ASP89_TCFG_SRC_HI   3
`define ASP89_TCFG_SRC_LO   1

// Baud timer clock source codes
`define ASP89_SRC_SYS       3'h0
`define ASP89_SRC_DIV4      3'h1
`define ASP89_SRC_DIV12     3'h2
`define ASP89_SRC_DIV48     3'h3
`define ASP89_SRC_EXT8      3'h4

// Prescaler terminal counts: 4, then x3 for 12, then x4 for 48; ext by 8
`define ASP89_DIV4_LAST     2'h3
`define ASP89_DIV12_LAST    2'h2
`define ASP89_DIV48_LAST    2'h3
`define ASP89_EXT_LAST      3'h7

// Reset values and other figures
`define ASP89_ZERO8         8'h00
`define ASP89_TMR_TOP       8'hff
`define ASP89_DATA_LAST     4'h7
`define ASP89_DATA_BITS     4'h8

`endif

// File: asp89_peer.sv
// Remote serial peer: drives the port's rx line, samples its tx line.
// Bit time in clock cycles is set by the bench through bit_cyc.
`default_nettype none
module asp89_peer (
    input wire logic ref_clk_in, // System clock
    input wire logic line_in,    // Port's tx line
    output var logic line_out    // Port's rx line
);
    timeunit 1ns;
    timeprecision 1ns;
    int bit_cyc = 8;
    initial line_out = 1'b1;
    task automatic send(input logic [7:0] d, input logic nine,
                        input logic b9, input logic stp);
        logic [11:0] f;
        f = nine ? {1'b1, stp, b9, d, 1'b0} : {2'b11, stp, d, 1'b0};
        for (int i = 0; i < (nine ? 12 : 11); i++) begin
            line_out <= f[i];
            repeat (bit_cyc) @(posedge ref_clk_in);
        end
    endtask
    // Samples mid-bit; returns right after the stop sample
    task automatic grab(input logic nine, output logic [10:0] f);
        int n;
        n = 0;
        f = '1;
        while (line_in !== 1'b0 && n < 400) begin
            @(posedge ref_clk_in);
            n++;
        end
        repeat (bit_cyc / 2) @(posedge ref_clk_in);
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            if (i > 0) repeat (bit_cyc) @(posedge ref_clk_in);
            f[i] = line_in;
        end
    endtask
endmodule
`default_nettype wire

// File: asp89_prescaler.v
// Timer clock source selector for the baud timer: one-cycle ticks at the
// system clock, system clock / 4, / 12, / 48, or external oscillator / 8.
// Assumes ext_osc_in is already synchronous to ref_clk_in.
`default_nettype none
`include "asp89_consts.vh"

module asp89_prescaler (
    input  wire       ref_clk_in,  // System clock
    input  wire       reset_n_in,  // Async reset, active low
    input  wire       run_in,      // Timer enable
    input  wire [2:0] src_sel_in,  // Clock source code
    input  wire       ext_osc_in,  // External oscillator level
    output reg        tick_out     // One-cycle timer clock tick
);
    reg  [1:0] div4_q;
    reg  [1:0] div12_q;
    reg  [1:0] div48_q;
    reg  [2:0] ext_q;
    reg        ext_prev_q;
    wire       t4;
    wire       t12;
    wire       t48;
    wire       ext_rise;
    wire       t_ext;
    reg        tick_d;

    assign t4       = (div4_q == `ASP89_DIV4_LAST);
    assign t12      = t4 && (div12_q == `ASP89_DIV12_LAST);
    assign t48      = t12 && (div48_q == `ASP89_DIV48_LAST);
    assign ext_rise = ext_osc_in && !ext_prev_q;
    assign t_ext    = ext_rise && (ext_q == `ASP89_EXT_LAST);

    always @* begin
        case (src_sel_in)
            `ASP89_SRC_SYS:   tick_d = 1'b1;
            `ASP89_SRC_DIV4:  tick_d = t4;
            `ASP89_SRC_DIV12: tick_d = t12;
            `ASP89_SRC_DIV48: tick_d = t48;
            `ASP89_SRC_EXT8:  tick_d = t_ext;
            default:          tick_d = 1'b0;
        endcase
    end

    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div4_q     <= 2'h0;
            div12_q    <= 2'h0;
            div48_q    <= 2'h0;
            ext_q      <= 3'h0;
            ext_prev_q <= 1'b0;
            tick_out   <= 1'b0;
        end else begin
            ext_prev_q <= ext_osc_in;
            tick_out   <= run_in && tick_d;
            div4_q     <= div4_q + 2'h1;
            if (t4) begin
                if (div12_q == `ASP89_DIV12_LAST)
                    div12_q <= 2'h0;
                else
                    div12_q <= div12_q + 2'h1;
            end
            if (t12)
                div48_q <= div48_q + 2'h1;
            if (ext_rise)
                ext_q <= ext_q + 3'h1;
        end
    end
endmodule
`default_nettype wire

// File: asp89_top.v
// Full-duplex asynchronous serial port with 8-bit and 9-bit framing,
// its baud timer, and a plain register port (read data one cycle later).
// Assumes all inputs are synchronous to ref_clk_in; the interrupt enable
// that gates the request output lives in the processor's own logic.
//
// Function
// - Control bit 7 selects eight or nine-bit frames
// - One data location: write transmits, read receives
// - Receiver shifts next byte while buffer held
// - Interrupt request on either done flag; software clears
// - Timer overflows halved give transmit and receive baud
// - Receive timer copy reloaded on start detection
// - Baud equals timer clock over 256-reload, halved
// - Timer clock chosen from five sources
// - Eight-bit frame: start, eight data, stop
// - Eight-bit mode stores stop bit as ninth bit
// - Data write starts; done flag at stop start
// - Reception only while receive enable bit set
// - Eight-bit accept: done clear, stop checked if enabled
// - Rejected character leaves buffer and flags alone
// - Overrun keeps first byte, drops the new one
// - Nine-bit frame: start, eight data, ninth, stop
// - Transmitted ninth bit comes from control bit 3
// - Nine-bit mode stores ninth bit, ignores stop
// - Nine-bit accept: done clear, ninth checked if enabled
// - Accepted nine-bit character loads buffer, ninth, done
// - Mode bit zero eight-bit, one nine-bit
// - Receive done set at stop-bit sample time
`default_nettype none
`include "asp89_consts.vh"

module asp89_top (
    input  wire       ref_clk_in,    // System clock, 100 MHz
    input  wire       reset_n_in,    // Async reset, active low
    input  wire [2:0] reg_addr_in,   // Register offset
    input  wire [7:0] reg_wdata_in,  // Write data
    input  wire       reg_wr_in,     // Write strobe
    input  wire       reg_rd_in,     // Read strobe
    output reg  [7:0] reg_rdata_out, // Read data, cycle after strobe
    input  wire       ext_osc_in,    // External oscillator level
    input  wire       rx_pin_in,     // Serial receive line
    output reg        tx_pin_out,    // Serial transmit line
    output wire       uart_irq_out   // Interrupt request, level
);
    localparam TX_IDLE  = 3'h0;
    localparam TX_WAIT  = 3'h1;
    localparam TX_START = 3'h2;
    localparam TX_DATA  = 3'h3;
    localparam TX_NINTH = 3'h4;
    localparam TX_STOP  = 3'h5;

    localparam RX_IDLE  = 3'h0;
    localparam RX_START = 3'h1;
    localparam RX_DATA  = 3'h2;
    localparam RX_NINTH = 3'h3;
    localparam RX_STOP  = 3'h4;

    // Control register fields
    reg        mode9_q;
    reg        mce_q;
    reg        ren_q;
    reg        tb8_q;
    reg        rb8_q;
    reg        ti_q;
    reg        ri_q;

    // Baud timer configuration
    reg  [7:0] reload_q;
    reg        run_q;
    reg  [2:0] src_q;

    // Transmitter
    reg  [2:0] tx_state_q;
    reg  [7:0] tx_sh_q;
    reg        tx_ninth_q;
    reg  [3:0] tx_cnt_q;
    reg        ti_set;

    // Receiver
    reg  [2:0] rx_state_q;
    reg  [7:0] rx_sh_q;
    reg        rx_ninth_q;
    reg  [3:0] rx_cnt_q;
    reg        rx_prev_q;
    reg  [7:0] rx_buf_q;
    reg        rx_load;
    reg        rx_load_bit;

    wire       timer_tick;
    wire [7:0] tx_count;
    wire       tx_baud;
    wire [7:0] rx_count_unused;
    wire       rx_baud;
    wire       start_seen;

    wire       wr_ctrl;
    wire       wr_data;
    wire       wr_reload;
    wire       wr_tcfg;
    wire       wr_tlow;
    wire       rx_stop_bit;
    wire       rx_check_bit;
    wire       rx_accept;

    assign wr_ctrl   = reg_wr_in && (reg_addr_in == `ASP89_OFS_CTRL);
    assign wr_data   = reg_wr_in && (reg_addr_in == `ASP89_OFS_DATA);
    assign wr_reload = reg_wr_in && (reg_addr_in == `ASP89_OFS_RELOAD);
    assign wr_tcfg   = reg_wr_in && (reg_addr_in == `ASP89_OFS_TMRCFG);
    assign wr_tlow   = reg_wr_in && (reg_addr_in == `ASP89_OFS_TMRLOW);

    // Either done flag raises the request until software clears it
    assign uart_irq_out = ti_q || ri_q;

    // Falling edge on an idle-high line while enabled and idle
    assign start_seen = ren_q && (rx_state_q == RX_IDLE) && rx_prev_q
                        && !rx_pin_in;

    asp89_prescaler u_pre (
        .ref_clk_in (ref_clk_in),
        .reset_n_in (reset_n_in),
        .run_in     (run_q),
        .src_sel_in (src_q),
        .ext_osc_in (ext_osc_in),
        .tick_out   (timer_tick)
    );

    // Software-visible transmit timer
    asp89_baud_timer u_tx_tmr (
        .ref_clk_in  (ref_clk_in),
        .reset_n_in  (reset_n_in),
        .tick_in     (timer_tick),
        .reload_in   (reload_q),
        .force_in    (1'b0),
        .load_in     (wr_tlow),
        .load_val_in (reg_wdata_in),
        .count_out   (tx_count),
        .baud_out    (tx_baud)
    );

    // Hidden receive copy: same clock and reload, own phase
    asp89_baud_timer u_rx_tmr (
        .ref_clk_in  (ref_clk_in),
        .reset_n_in  (reset_n_in),
        .tick_in     (timer_tick),
        .reload_in   (reload_q),
        .force_in    (start_seen),
        .load_in     (1'b0),
        .load_val_in (`ASP89_ZERO8),
        .count_out   (rx_count_unused),
        .baud_out    (rx_baud)
    );

    // Register writes; hardware sets of the flags win over software
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode9_q  <= 1'b0;
            mce_q    <= 1'b0;
            ren_q    <= 1'b0;
            tb8_q    <= 1'b0;
            rb8_q    <= 1'b0;
            ti_q     <= 1'b0;
            ri_q     <= 1'b0;
            reload_q <= `ASP89_ZERO8;
            run_q    <= 1'b0;
            src_q    <= `ASP89_SRC_SYS;
            rx_buf_q <= `ASP89_ZERO8;
        end else begin
            if (wr_ctrl) begin
                mode9_q <= reg_wdata_in[`ASP89_CTL_MODE];
                mce_q   <= reg_wdata_in[`ASP89_CTL_MCE];
                ren_q   <= reg_wdata_in[`ASP89_CTL_REN];
                tb8_q   <= reg_wdata_in[`ASP89_CTL_TB8];
            end
            if (rx_load) begin
                rb8_q    <= rx_load_bit;
                rx_buf_q <= rx_sh_q;
            end else if (wr_ctrl) begin
                rb8_q <= reg_wdata_in[`ASP89_CTL_RB8];
            end
            if (ti_set)
                ti_q <= 1'b1;
            else if (wr_ctrl)
                ti_q <= reg_wdata_in[`ASP89_CTL_TI];
            if (rx_load)
                ri_q <= 1'b1;
            else if (wr_ctrl)
                ri_q <= reg_wdata_in[`ASP89_CTL_RI];
            if (wr_reload)
                reload_q <= reg_wdata_in;
            if (wr_tcfg) begin
                run_q <= reg_wdata_in[`ASP89_TCFG_RUN];
                src_q <= reg_wdata_in[`ASP89_TCFG_SRC_HI:`ASP89_TCFG_SRC_LO];
            end
        end
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= `ASP89_ZERO8;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `ASP89_OFS_CTRL:   reg_rdata_out <= {mode9_q, 1'b1, mce_q,
                                       ren_q, tb8_q, rb8_q, ti_q, ri_q};
                `ASP89_OFS_DATA:   reg_rdata_out <= rx_buf_q;
                `ASP89_OFS_RELOAD: reg_rdata_out <= reload_q;
                `ASP89_OFS_TMRCFG: reg_rdata_out <= {4'h0, src_q, run_q};
                `ASP89_OFS_TMRLOW: reg_rdata_out <= tx_count;
                default:           reg_rdata_out <= `ASP89_ZERO8;
            endcase
        end else begin
            reg_rdata_out <= `ASP89_ZERO8;
        end
    end

    // Transmitter. A data write while a frame is under way is ignored so
    // the frame on the wire is never corrupted mid-character.
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_state_q <= TX_IDLE;
            tx_sh_q    <= `ASP89_ZERO8;
            tx_ninth_q <= 1'b0;
            tx_cnt_q   <= 4'h0;
            tx_pin_out <= 1'b1;
            ti_set     <= 1'b0;
        end else begin
            ti_set <= 1'b0;
            case (tx_state_q)
                TX_IDLE: begin
                    tx_pin_out <= 1'b1;
                    if (wr_data) begin
                        tx_sh_q    <= reg_wdata_in;
                        tx_ninth_q <= tb8_q;
                        tx_state_q <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    // Frame aligns to the free-running transmit timer
                    if (tx_baud) begin
                        tx_pin_out <= 1'b0;
                        tx_state_q <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_baud) begin
                        tx_pin_out <= tx_sh_q[0];
                        tx_sh_q    <= {1'b0, tx_sh_q[7:1]};
                        tx_cnt_q   <= 4'h1;
                        tx_state_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_baud) begin
                        if (tx_cnt_q == `ASP89_DATA_BITS) begin
                            if (mode9_q) begin
                                tx_pin_out <= tx_ninth_q;
                                tx_state_q <= TX_NINTH;
                            end else begin
                                tx_pin_out <= 1'b1;
                                ti_set     <= 1'b1;
                                tx_state_q <= TX_STOP;
                            end
                        end else begin
                            tx_pin_out <= tx_sh_q[0];
                            tx_sh_q    <= {1'b0, tx_sh_q[7:1]};
                            tx_cnt_q   <= tx_cnt_q + 4'h1;
                        end
                    end
                end
                TX_NINTH: begin
                    if (tx_baud) begin
                        tx_pin_out <= 1'b1;
                        ti_set     <= 1'b1;
                        tx_state_q <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_baud)
                        tx_state_q <= TX_IDLE;
                end
                default: begin
                    tx_pin_out <= 1'b1;
                    tx_state_q <= TX_IDLE;
                end
            endcase
        end
    end

    // Acceptance at the stop-bit sample. The check bit is the stop bit in
    // eight-bit mode and the ninth data bit in nine-bit mode.
    assign rx_stop_bit  = rx_pin_in;
    assign rx_check_bit = mode9_q ? rx_ninth_q : rx_stop_bit;
    assign rx_accept    = !ri_q && (!mce_q || rx_check_bit);

    // Receiver. The shift register is separate from the buffer so a new
    // character can come in while software still holds the last one.
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_state_q  <= RX_IDLE;
            rx_sh_q     <= `ASP89_ZERO8;
            rx_ninth_q  <= 1'b0;
            rx_cnt_q    <= 4'h0;
            rx_prev_q   <= 1'b1;
            rx_load     <= 1'b0;
            rx_load_bit <= 1'b0;
        end else begin
            rx_prev_q <= rx_pin_in;
            rx_load   <= 1'b0;
            if (!ren_q) begin
                rx_state_q <= RX_IDLE;
            end else begin
                case (rx_state_q)
                    RX_IDLE: begin
                        if (start_seen)
                            rx_state_q <= RX_START;
                    end
                    RX_START: begin
                        // Mid-start sample rejects glitches as false starts
                        if (rx_baud) begin
                            rx_cnt_q   <= 4'h0;
                            rx_state_q <= rx_pin_in ? RX_IDLE
                                                    : RX_DATA;
                        end
                    end
                    RX_DATA: begin
                        if (rx_baud) begin
                            rx_sh_q  <= {rx_pin_in, rx_sh_q[7:1]};
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q == `ASP89_DATA_LAST)
                                rx_state_q <= mode9_q ? RX_NINTH : RX_STOP;
                        end
                    end
                    RX_NINTH: begin
                        if (rx_baud) begin
                            rx_ninth_q <= rx_pin_in;
                            rx_state_q <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_baud) begin
                            // Rejected or overrun: buffer, flags untouched
                            rx_load     <= rx_accept;
                            rx_load_bit <= rx_check_bit;
                            rx_state_q  <= RX_IDLE;
                        end
                    end
                    default: rx_state_q <= RX_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: asp89_top_asserts.sv
// Checker for the serial port: register port, interrupt level, tx line.
// Sees only asp89_top ports; bound to every instance at the foot.
`default_nettype none
module asp89_chk (
    input wire logic       ref_clk_in,    // System clock
    input wire logic       reset_n_in,    // Async reset, active low
    input wire logic [2:0] reg_addr_in,   // Register offset
    input wire logic [7:0] reg_wdata_in,  // Write data
    input wire logic       reg_wr_in,     // Write strobe
    input wire logic       reg_rd_in,     // Read strobe
    input wire logic [7:0] reg_rdata_out, // Read data
    input wire logic       tx_pin_out,    // Serial transmit line
    input wire logic       uart_irq_out   // Interrupt request
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    logic [7:0] w_q;
    always_ff @(posedge ref_clk_in) if (reg_wr_in) w_q <= reg_wdata_in;
    property p_rd_idle;
        !reg_rd_in |=> reg_rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not zero outside read");
    property p_unmapped;
        reg_rd_in && reg_addr_in > 3'h4 |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped offset read not zero");
    property p_ctrl_wr;
        reg_wr_in && reg_addr_in == 3'h0 ##1 reg_rd_in && reg_addr_in == 3'h0
        |=> reg_rdata_out[7:3] == {w_q[7], 1'b1, w_q[5:3]};
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr)
        else $error("control bits not kept");
    property p_reload;
        reg_wr_in && reg_addr_in == 3'h2 ##1 reg_rd_in && reg_addr_in == 3'h2
        |=> reg_rdata_out == w_q;
    endproperty
    a_reload: assert property (p_reload)
        else $error("reload byte not kept");
    property p_tmrcfg;
        reg_wr_in && reg_addr_in == 3'h3 ##1 reg_rd_in && reg_addr_in == 3'h3
        |=> reg_rdata_out == {4'h0, w_q[3:0]};
    endproperty
    a_tmrcfg: assert property (p_tmrcfg)
        else $error("timer source not kept");
    property p_irq_hold;
        uart_irq_out && !(reg_wr_in && reg_addr_in == 3'h0) |=> uart_irq_out;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without software clear");
    property p_irq_rd;
        reg_rd_in && reg_addr_in == 3'h0
        |=> (|reg_rdata_out[1:0]) == $past(uart_irq_out);
    endproperty
    a_irq_rd: assert property (p_irq_rd)
        else $error("interrupt differs from done flags");
    property p_tx_min;
        $fell(tx_pin_out) |=> !tx_pin_out;
    endproperty
    a_tx_min: assert property (p_tx_min)
        else $error("tx start shorter than two cycles");
endmodule
bind asp89_top asp89_chk u_chk (
    .ref_clk_in    (ref_clk_in),
    .reset_n_in    (reset_n_in),
    .reg_addr_in   (reg_addr_in),
    .reg_wdata_in  (reg_wdata_in),
    .reg_wr_in     (reg_wr_in),
    .reg_rd_in     (reg_rd_in),
    .reg_rdata_out (reg_rdata_out),
    .tx_pin_out    (tx_pin_out),
    .uart_irq_out  (uart_irq_out)
);
`default_nettype wire

// File: asp89_top_bench.sv
// Self-checking bench for asp89_top: registers, timer sources, tx and
// rx framing in both modes, acceptance rules and overrun.
`default_nettype none
`define CHK(n, e, g) begin comparisons++; \
    if ((g) !== (e)) begin mismatches++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module asp89_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk_in, reset_n_in, reg_wr_in, reg_rd_in;
    logic        ext_osc_in, rx_pin_in, tx_pin_out, uart_irq_out;
    logic [2:0]  reg_addr_in;
    logic [7:0]  reg_wdata_in, reg_rdata_out, rv, d, d2, rxbuf;
    logic [10:0] f;
    int          mismatches, comparisons, cycles;
    logic [2:0]  src [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    logic [7:0]  rl [5] = '{8'hfe, 8'hff, 8'hff, 8'hff, 8'hfc};
    int          bc [5] = '{16, 24, 96, 32, 8};
    // {control, nine, ninth, stop, accepted}
    logic [11:0] rxt [7] = '{12'h103, 12'h101, 12'h300, 12'h909,
                             12'hb0a, 12'hb0f, 12'h002};

    asp89_top dut (
        .ref_clk_in    (ref_clk_in),
        .reset_n_in    (reset_n_in),
        .reg_addr_in   (reg_addr_in),
        .reg_wdata_in  (reg_wdata_in),
        .reg_wr_in     (reg_wr_in),
        .reg_rd_in     (reg_rd_in),
        .reg_rdata_out (reg_rdata_out),
        .ext_osc_in    (ext_osc_in),
        .rx_pin_in     (rx_pin_in),
        .tx_pin_out    (tx_pin_out),
        .uart_irq_out  (uart_irq_out)
    );
    asp89_peer peer (
        .ref_clk_in (ref_clk_in),
        .line_in    (tx_pin_out),
        .line_out   (rx_pin_in)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    always @(posedge ref_clk_in) begin
        ext_osc_in <= ~ext_osc_in;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [2:0] rx_exp(logic [11:0] t);
        return {t[0] & (t[3] ? t[2] : t[1]), 1'b0, t[0]};
    endfunction
    task automatic rd(input logic [2:0] a);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 rv = reg_rdata_out;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] w);
        @(posedge ref_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= w;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in);
        reg_rd_in <= 1'b0;
        #1 rv = reg_rdata_out;
    endtask
    task automatic tx_chk(input logic nine, input logic b9);
        d = 8'($urandom());
        wr(3'h1, d);
        peer.grab(nine, f);
        `CHK("tx frame", {1'b1, nine ? b9 : 1'b1, d, 1'b0}, f)
        `CHK("tx done irq", 1'b1, uart_irq_out)
        repeat (peer.bit_cyc) @(posedge ref_clk_in);
    endtask

    initial begin
        reset_n_in = 1'b0;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        reg_addr_in = 3'h0;
        reg_wdata_in = 8'h00;
        ext_osc_in = 1'b0;
        rxbuf = 8'h00;
        void'($urandom(51161));
        repeat (2) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(3'(a));
            `CHK("reset value", (a == 0) ? 8'h40 : 8'h00, rv)
        end
        for (int a = 5; a < 8; a++) begin
            wr(3'(a), 8'($urandom()));
            `CHK("unmapped", 8'h00, rv)
        end
        wr(3'h4, 8'hff);
        `CHK("timer low", 8'hff, rv)
        // Every timer source
        for (int i = 0; i < 5; i++) begin
            wr(3'h2, rl[i]);
            `CHK("reload", rl[i], rv)
            wr(3'h3, {4'h0, src[i], 1'b1});
            `CHK("timer cfg", {4'h0, src[i], 1'b1}, rv)
            wr(3'h0, 8'h00);
            `CHK("irq cleared", 1'b0, uart_irq_out)
            peer.bit_cyc = bc[i];
            repeat (4 * bc[i]) @(posedge ref_clk_in);
            tx_chk(1'b0, 1'b0);
        end
        for (int b = 0; b < 2; b++) begin
            wr(3'h0, {1'b1, 3'h0, 1'(b), 3'h0});
            tx_chk(1'b1, 1'(b));
        end
        foreach (rxt[i]) begin
            wr(3'h0, rxt[i][11:4]);
            d = 8'($urandom());
            peer.send(d, rxt[i][3], rxt[i][2], rxt[i][1]);
            repeat (4) @(posedge ref_clk_in);
            rd(3'h0);
            `CHK("rx flags", rx_exp(rxt[i]), rv[2:0])
            if (rxt[i][0]) rxbuf = d;
            rd(3'h1);
            `CHK("rx data", rxbuf, rv)
        end
        // Second byte arrives while the first is still unread
        wr(3'h0, 8'h10);
        d = 8'($urandom());
        d2 = 8'($urandom());
        peer.send(d, 1'b0, 1'b0, 1'b1);
        fork
            peer.send(d2, 1'b0, 1'b0, 1'b1);
            begin
                repeat (20) @(posedge ref_clk_in);
                rd(3'h1);
                `CHK("first byte", d, rv)
                wr(3'h0, 8'h10);
            end
        join
        repeat (4) @(posedge ref_clk_in);
        rd(3'h1);
        `CHK("second byte", d2, rv)
        peer.send(d, 1'b0, 1'b0, 1'b1);
        repeat (4) @(posedge ref_clk_in);
        rd(3'h1);
        `CHK("overrun keeps", d2, rv)
        `CHK("rx done irq", 1'b1, uart_irq_out)
        print_verdict();
    end
endmodule
`default_nettype wire
